/* lan_ctrl_counter_boot_diag_csrs_tb.sv */
// testbench: counter, boot, breakpoint, examine and test pin checks
`timescale 1ns/100ps
`default_nettype none
module lan_ctrl_counter_boot_diag_csrs_tb;
  localparam logic [4:0] REV = 5'h0A;  // arbitrary value
  logic        mclk = 1'h0, reset = 1'h1, fm = 1'h0, ben = 1'h0, tpm = 1'h0;
  logic        bv = 1'h0, bb = 1'h0, bf = 1'h0, wsn = 1'h1, match, halt, ereq, wr, rd;
  logic [1:0]  om = 2'h0;
  logic [3:0]  pins;
  logic [14:0] rst_a;
  logic [15:0] pc = 16'h0, ea, erd = 16'h0, db = 16'hA5C3, ab = 16'h3B7E;
  logic [31:0] addr, wd, rdat, r;
  int          mismatches = 0, total_checks = 0;
  always #12.5 mclk = ~mclk;
  lcb_host_model i_host (.mclk(mclk), .bus_addr(addr), .bus_wdata(wd), .bus_wr(wr),
    .bus_rd(rd), .bus_rdata(rdat));
  lcb_csrs #(.CHIP_REV(REV)) i_dut (.mclk(mclk), .reset(reset), .bus_addr(addr),
    .bus_wdata(wd), .bus_wr(wr), .bus_rd(rd), .bus_rdata(rdat), .frame_missed(fm),
    .boot_msg_enable(ben), .operating_mode_field(om), .test_pin_mode(tpm),
    .boot_bit_valid(bv), .boot_bit(bb), .boot_bit_first(bf), .boot_verify_match(match),
    .proc_pc(pc), .proc_halt(halt), .proc_restart_addr(rst_a), .exam_addr(ea),
    .exam_req(ereq), .exam_rdata(erd), .int_data_bus(db), .int_addr_bus(ab),
    .internal_write_strobe_n(wsn), .test_monitor_pins(pins));
  // ========================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    i_host.rd(a, r);
    chk(r, exp);
  endtask
  task automatic send(input logic [63:0] v);
    for (int i = 0; i < 64; i++) begin
      @(posedge mclk);
      bv <= 1'h1;
      bb <= v[i];
      bf <= (i == 0);
    end
    @(posedge mclk);
    bv <= 1'h0;
    @(negedge mclk);
  endtask
  function automatic logic [3:0] pin_exp(input logic [2:0] s);
    logic [15:0] b;
    b = s[0] ? ab : db;
    if (s == 3'h7) return {1'h0, wsn, ab[13:12]};
    return b[4*s[2:1] +: 4];
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    complete_run();
  end
  // ========================================
  // main sequence
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'h0;
    rdc(lcb_pkg::REVMF_ADDR, {11'h0, REV, 16'h0});
    rdc(lcb_pkg::BOOTLO_ADDR, 32'h0);
    rdc(lcb_pkg::BOOTHI_ADDR, 32'h0);
    rdc(lcb_pkg::BOOTPR_ADDR, 32'h0);
    rdc(lcb_pkg::BKPT_ADDR, 32'h0);
    rdc(lcb_pkg::MONCMD_ADDR, lcb_pkg::MONCMD_RST);
    rdc(32'h20008044, 32'h0);
    // three dropped frames
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      fm <= ~fm;
    end
    i_host.wr(lcb_pkg::REVMF_ADDR, 32'hFFFFFFFF);
    rdc(lcb_pkg::REVMF_ADDR, {11'h0, REV, 16'h3});
    fork
      rdc(lcb_pkg::REVMF_ADDR, {11'h0, REV, 16'h0});
      begin
        @(posedge mclk);
        fm <= 1'h1;
        @(posedge mclk);
        fm <= 1'h0;
      end
    join
    rdc(lcb_pkg::REVMF_ADDR, {11'h0, REV, 16'h1});
    i_host.wr(lcb_pkg::BOOTLO_ADDR, 32'h89ABCDEF);
    i_host.wr(lcb_pkg::BOOTHI_ADDR, 32'h01234567);
    i_host.wr(lcb_pkg::BOOTPR_ADDR, 32'h0000005A);
    ben <= 1'h1;
    i_host.wr(lcb_pkg::BOOTLO_ADDR, 32'h0);
    rdc(lcb_pkg::BOOTLO_ADDR, 32'h89ABCDEF);
    rdc(lcb_pkg::BOOTHI_ADDR, 32'h01234567);
    rdc(lcb_pkg::BOOTPR_ADDR, 32'h0000005A);
    send(64'h0123456789ABCDEF);
    chk({31'h0, match}, 32'h1);
    send(64'h0123456789ABCDEE);
    chk({31'h0, match}, 32'h0);
    @(posedge mclk);
    ben <= 1'h0;
    om <= 2'h2;
    i_host.wr(lcb_pkg::BKPT_ADDR, 32'hC0051234);
    rdc(lcb_pkg::BKPT_ADDR, 32'h0);
    // diag ready taken as set: no flag reaches this block
    om <= lcb_pkg::OM_DIAG;
    i_host.wr(lcb_pkg::BKPT_ADDR, 32'hC0051234);
    rdc(lcb_pkg::BKPT_ADDR, 32'hC0051234);
    pc <= 16'h1234;
    @(negedge mclk);
    chk({16'h0, halt, rst_a}, 32'h0000C005);
    @(posedge mclk);
    pc <= 16'h1235;
    @(negedge mclk);
    chk({31'h0, halt}, 32'h0);
    @(posedge mclk);
    erd <= 16'hBEEF;
    i_host.wr(lcb_pkg::MONCMD_ADDR, 32'h12348000);
    @(negedge mclk);
    chk({15'h0, ereq, ea}, 32'h00011234);
    repeat (4) @(posedge mclk);
    i_host.rd(lcb_pkg::MONCMD_ADDR, r);
    chk({r[31:15], ereq, 14'h0}, 32'hBEEF0000);
    tpm <= 1'h1;
    for (int q = 0; q < 8; q++) begin
      i_host.wr(lcb_pkg::MONCMD_ADDR, {17'h0, q[2:0], 12'h0});
      repeat (2) @(negedge mclk);
      chk({28'h0, pins}, {28'h0, pin_exp(q[2:0])});
    end
    // write strobe low must show on the address top nibble
    @(posedge mclk);
    wsn <= 1'h0;
    repeat (2) @(negedge mclk);
    chk({28'h0, pins}, {28'h0, pin_exp(3'h7)});
    @(posedge mclk);
    tpm <= 1'h0;
    repeat (2) @(negedge mclk);
    chk({28'h0, pins}, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire

/* lcb_csrs.sv */
// module: counter, boot message, breakpoint and monitor command registers
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - top eleven bits of revision/counter register read zero, writes ignored
// - chip revision shows as read-only five-bit field
// - missed-frame counter counts frames dropped for lack of buffers
// - reading revision/counter returns the count then clears it
// - 64-bit boot verification over two registers plus 8-bit processor field
// - first received verification bit maps to bit zero
// - reset clears all three boot-message registers
// - breakpoint register written only in diagnostic mode, code 11
// - armed breakpoint halts processor at match, jumps to restart address
// - examine trigger fetches addressed location, data replaces field after three cycles
// - hardware clears examine trigger when examine finishes
// - nibble select picks four bits of monitored bus for test pins, except address top nibble: zero, write strobe, address bits 13:12
// - bus-choice bit picks data bus clear, address bus set
module lcb_csrs #(
  parameter logic [4:0] CHIP_REV = 5'h01  // arbitrary value
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [31:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [31:0] bus_rdata,
  input  wire logic        frame_missed,
  input  wire logic        boot_msg_enable,
  input  wire logic [1:0]  operating_mode_field,
  input  wire logic        test_pin_mode,
  input  wire logic        boot_bit_valid,
  input  wire logic        boot_bit,
  input  wire logic        boot_bit_first,
  output logic             boot_verify_match,
  input  wire logic [15:0] proc_pc,
  output logic             proc_halt,
  output logic      [14:0] proc_restart_addr,
  output logic      [15:0] exam_addr,
  output logic             exam_req,
  input  wire logic [15:0] exam_rdata,
  input  wire logic [15:0] int_data_bus,
  input  wire logic [15:0] int_addr_bus,
  input  wire logic        internal_write_strobe_n,
  output logic      [3:0]  test_monitor_pins
);
  // ===========================================================================
  // decode
  lcb_pkg::lcb_bus_req_t req;
  assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

  // every address bit is compared: an alias would let a stray read clear the counter
  function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] base);
    return a == base;
  endfunction

  wire sel_revmf  = addr_hit(req.addr, lcb_pkg::REVMF_ADDR);
  wire sel_bootlo = addr_hit(req.addr, lcb_pkg::BOOTLO_ADDR);
  wire sel_boothi = addr_hit(req.addr, lcb_pkg::BOOTHI_ADDR);
  wire sel_bootpr = addr_hit(req.addr, lcb_pkg::BOOTPR_ADDR);
  wire sel_bkpt   = addr_hit(req.addr, lcb_pkg::BKPT_ADDR);
  wire sel_moncmd = addr_hit(req.addr, lcb_pkg::MONCMD_ADDR);

  // ===========================================================================
  // missed frame counter
  logic [15:0] mfc_reg;
  logic [15:0] mfc_next;
  wire         mfc_clr = req.rd && sel_revmf;
  assign mfc_next = mfc_clr ? {15'h0000, frame_missed} :
                    (frame_missed ? mfc_reg + 16'h0001 : mfc_reg);
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) mfc_reg <= 16'h0000;
    else       mfc_reg <= mfc_next;
  end

  // ===========================================================================
  // boot message registers
  logic [31:0] bootlo_reg;
  logic [31:0] boothi_reg;
  logic [7:0]  bootpr_reg;
  // boot enable gates writes so the compare never sees a half-written code
  wire boot_wr_ok = req.wr && !boot_msg_enable;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bootlo_reg <= lcb_pkg::ZERO_RST;
      boothi_reg <= lcb_pkg::ZERO_RST;
      bootpr_reg <= 8'h00;
    end else begin
      if (boot_wr_ok && sel_bootlo) bootlo_reg <= req.wdata;
      if (boot_wr_ok && sel_boothi) boothi_reg <= req.wdata;
      if (boot_wr_ok && sel_bootpr) bootpr_reg <= req.wdata[7:0];
    end
  end

  // serial compare: bit index advances from zero
  logic [5:0] vbit_reg;
  logic       vok_reg;
  wire [63:0] vcode = {boothi_reg, bootlo_reg};
  wire [5:0]  vidx  = boot_bit_first ? 6'h00 : vbit_reg;
  wire        vok_in = boot_bit_first ? 1'b1 : vok_reg;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      vbit_reg <= 6'h00;
      vok_reg  <= 1'b0;
    end else if (boot_bit_valid) begin
      vbit_reg <= vidx + 6'h01;
      vok_reg  <= vok_in && (boot_bit == vcode[vidx]);
    end
  end
  assign boot_verify_match = vok_reg;

  // ===========================================================================
  // breakpoint register
  lcb_pkg::lcb_bkpt_t bkpt_reg;
  wire bkpt_wr = req.wr && sel_bkpt && operating_mode_field == lcb_pkg::OM_DIAG;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)        bkpt_reg <= lcb_pkg::ZERO_RST;
    else if (bkpt_wr) bkpt_reg <= req.wdata;
  end
  assign proc_halt         = bkpt_reg.arm && proc_pc == bkpt_reg.match;
  assign proc_restart_addr = bkpt_reg.restart;

  // ===========================================================================
  // monitor command and examine
  logic [15:0] mon_field_reg;
  logic        trig_reg;
  logic [1:0]  nib_reg;
  logic        bsel_reg;
  logic [1:0]  exam_cnt_reg;
  wire mon_wr = req.wr && sel_moncmd;
  wire exam_done = trig_reg && exam_cnt_reg == 2'(lcb_pkg::EXAMINE_CYC - 1);
  // the examine counter is two bits wide, so a longer fetch would wrap its end count and finish early
  if (lcb_pkg::EXAMINE_CYC < 1 || lcb_pkg::EXAMINE_CYC > 4) begin : g_exam_cyc_bad
    $error("examine cycle count does not fit the counter");
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mon_field_reg <= lcb_pkg::MONCMD_RST[31:16];
      trig_reg      <= lcb_pkg::MONCMD_RST[15];
      nib_reg       <= lcb_pkg::MONCMD_RST[14:13];
      bsel_reg      <= lcb_pkg::MONCMD_RST[12];
      exam_cnt_reg  <= 2'h0;
    end else if (exam_done) begin
      mon_field_reg <= exam_rdata;
      trig_reg      <= 1'b0;
      exam_cnt_reg  <= 2'h0;
    end else if (trig_reg) begin
      exam_cnt_reg  <= exam_cnt_reg + lcb_pkg::EXAM_CNT_W1;
    end else if (mon_wr) begin
      mon_field_reg <= req.wdata[31:16];
      trig_reg      <= req.wdata[lcb_pkg::MON_TRIG_BIT];
      nib_reg       <= req.wdata[14:13];
      bsel_reg      <= req.wdata[lcb_pkg::MON_BUS_BIT];
    end
  end
  assign exam_addr = mon_field_reg;
  assign exam_req  = trig_reg;

  wire [15:0] mon_bus = bsel_reg ? int_addr_bus : int_data_bus;
  wire [3:0]  top_nib = bsel_reg ? {1'b0, internal_write_strobe_n, int_addr_bus[13:12]}
                                 : int_data_bus[15:12];
  logic [3:0] pins_reg;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) pins_reg <= 4'h0;
    else if (!test_pin_mode) pins_reg <= 4'h0;
    else case (nib_reg)
      2'h0:    pins_reg <= mon_bus[3:0];
      2'h1:    pins_reg <= mon_bus[7:4];
      2'h2:    pins_reg <= mon_bus[11:8];
      default: pins_reg <= top_nib;
    endcase
  end
  assign test_monitor_pins = pins_reg;

  // ===========================================================================
  // read data, one cycle after the strobe
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  wire [31:0] revmf_word = {11'h000, CHIP_REV, mfc_reg};
  always_comb begin
    rdata_next = 32'h00000000;
    if (sel_revmf)  rdata_next = revmf_word;
    if (sel_bootlo) rdata_next = bootlo_reg;
    if (sel_boothi) rdata_next = boothi_reg;
    if (sel_bootpr) rdata_next = {24'h000000, bootpr_reg};
    if (sel_bkpt)   rdata_next = bkpt_reg;
    if (sel_moncmd) rdata_next = {mon_field_reg, trig_reg, nib_reg, bsel_reg, 12'hFFF};
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)       rdata_reg <= 32'h00000000;
    else if (req.rd) rdata_reg <= rdata_next;
    else             rdata_reg <= 32'h00000000;
  end
  assign bus_rdata = rdata_reg;

  // ===========================================================================
  // checks
  sequence s_trig_start;
    !trig_reg ##1 trig_reg;
  endsequence
  sequence s_exam_end;
    ##(2) trig_reg ##1 !trig_reg;
  endsequence
  AST_REV_TOP: assert property (@(posedge mclk) disable iff (reset)
    $past(req.rd) |-> bus_rdata[31:21] == 11'h000 || !$past(sel_revmf))
    else $error("revision top bits not zero");
  AST_REV_NUM: assert property (@(posedge mclk) disable iff (reset)
    $past(req.rd && sel_revmf) |-> bus_rdata[20:16] == CHIP_REV)
    else $error("revision field wrong");
  AST_REV_WR: assert property (@(posedge mclk) disable iff (reset)
    req.wr && sel_revmf && !frame_missed |=> $stable(mfc_reg))
    else $error("revision register took a write");
  AST_MFC_INC: assert property (@(posedge mclk) disable iff (reset)
    frame_missed && !mfc_clr && mfc_reg != 16'hFFFF |=> mfc_reg == $past(mfc_reg) + 16'h0001)
    else $error("missed count not incremented");
  AST_MFC_CLR: assert property (@(posedge mclk) disable iff (reset)
    mfc_clr && !frame_missed |=> mfc_reg == 16'h0000 && bus_rdata[15:0] == $past(mfc_reg))
    else $error("read did not clear counter");
  AST_MFC_RACE: assert property (@(posedge mclk) disable iff (reset)
    mfc_clr && frame_missed |=> mfc_reg == 16'h0001)
    else $error("coincident miss lost");

  // counter holds when neither a miss nor a clearing read arrives
  AST_MFC_HOLD: assert property (@(posedge mclk) disable iff (reset)
    !frame_missed && !mfc_clr |=> $stable(mfc_reg))
    else $error("missed count moved without cause");
  AST_BOOT_HOLD: assert property (@(posedge mclk) disable iff (reset)
    boot_msg_enable |=> bootlo_reg == $past(bootlo_reg) && boothi_reg == $past(boothi_reg))
    else $error("boot code changed while enabled");
  AST_BOOT_PRC: assert property (@(posedge mclk) disable iff (reset)
    boot_msg_enable |=> $stable(bootpr_reg))
    else $error("boot processor field changed while enabled");
  AST_BOOT_LOAD: assert property (@(posedge mclk) disable iff (reset)
    boot_wr_ok && sel_bootlo |=> bootlo_reg == $past(req.wdata))
    else $error("boot low word not loaded");
  AST_VRF_BIT0: assert property (@(posedge mclk) disable iff (reset)
    boot_bit_valid && boot_bit_first |=> vok_reg == ($past(boot_bit) == $past(bootlo_reg[0])))
    else $error("first bit not against bit zero");
  AST_VRF_MISS: assert property (@(posedge mclk) disable iff (reset)
    boot_bit_valid && boot_bit != vcode[vidx] |=> !vok_reg)
    else $error("mismatching boot bit not caught");
  AST_BKPT_GATE: assert property (@(posedge mclk) disable iff (reset)
    operating_mode_field != lcb_pkg::OM_DIAG |=> bkpt_reg == $past(bkpt_reg))
    else $error("breakpoint written outside diagnostic");
  AST_BKPT_LOAD: assert property (@(posedge mclk) disable iff (reset)
    bkpt_wr |=> bkpt_reg == $past(req.wdata))
    else $error("breakpoint write in diagnostic mode lost");
  AST_HALT: assert property (@(posedge mclk) disable iff (reset)
    proc_halt |-> bkpt_reg.arm && proc_pc == bkpt_reg.match)
    else $error("halt without armed match");
  AST_EXAM: assert property (@(posedge mclk) disable iff (reset)
    s_trig_start |-> s_exam_end)
    else $error("examine not done in three cycles");

  // the fetch address must not move under the internal read
  AST_TRIG_LOAD: assert property (@(posedge mclk) disable iff (reset)
    mon_wr && !trig_reg && req.wdata[lcb_pkg::MON_TRIG_BIT] |=>
      exam_req && exam_addr == $past(req.wdata[31:16]))
    else $error("examine did not start from written address");
  AST_EXAM_HOLD: assert property (@(posedge mclk) disable iff (reset)
    exam_req && !exam_done |=> $stable(exam_addr))
    else $error("examine address moved during fetch");
  AST_EXAM_DATA: assert property (@(posedge mclk) disable iff (reset)
    exam_done |=> !trig_reg && mon_field_reg == $past(exam_rdata))
    else $error("examine data or trigger clear wrong");
  AST_PINS: assert property (@(posedge mclk) disable iff (reset)
    test_pin_mode && nib_reg == 2'h0 |=> test_monitor_pins == $past(mon_bus[3:0]))
    else $error("nibble zero not routed");
  AST_BUS: assert property (@(posedge mclk) disable iff (reset)
    test_pin_mode && nib_reg == 2'h1 && bsel_reg |=> test_monitor_pins == $past(int_addr_bus[7:4]))
    else $error("address bus not routed");

  // test pins: address top nibble, data nibbles one and two, and quiet outside test mode
  AST_PINS_OFF: assert property (@(posedge mclk) disable iff (reset)
    !test_pin_mode |=> test_monitor_pins == 4'h0)
    else $error("test pins active outside test mode");
  AST_PINS_TOP: assert property (@(posedge mclk) disable iff (reset)
    test_pin_mode && nib_reg == 2'h3 && bsel_reg |=>
      test_monitor_pins == {1'h0, $past(internal_write_strobe_n), $past(int_addr_bus[13:12])})
    else $error("address top nibble not routed");
  AST_DATA_NIB1: assert property (@(posedge mclk) disable iff (reset)
    test_pin_mode && nib_reg == 2'h1 && !bsel_reg |=>
      test_monitor_pins == $past(int_data_bus[7:4]))
    else $error("data bus nibble one not routed");
  AST_DATA_NIB2: assert property (@(posedge mclk) disable iff (reset)
    test_pin_mode && nib_reg == 2'h2 && !bsel_reg |=>
      test_monitor_pins == $past(int_data_bus[11:8]))
    else $error("data bus nibble two not routed");
endmodule
`default_nettype wire

/* lcb_host_model.sv */
// host software model: csr reads and writes on the register port
`timescale 1ns/100ps
`default_nettype none
module lcb_host_model (
  input  wire logic        mclk,
  output logic      [31:0] bus_addr,
  output logic      [31:0] bus_wdata,
  output logic             bus_wr,
  output logic             bus_rd,
  input  wire logic [31:0] bus_rdata
);
  initial {bus_addr, bus_wdata, bus_wr, bus_rd} = 66'h0;
  // ========================================
  // accesses: idle lines carry the inverse so a stale value never passes
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus_wr    <= 1'h1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge mclk);
    bus_wr    <= 1'h0;
    bus_addr  <= ~a;
    bus_wdata <= ~d;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge mclk);
    bus_rd   <= 1'h1;
    bus_addr <= a;
    @(posedge mclk);
    bus_rd   <= 1'h0;
    bus_addr <= ~a;
    @(negedge mclk);
    d = bus_rdata;
    // return on a rising edge so callers keep driving inputs there
    @(posedge mclk);
  endtask
endmodule
`default_nettype wire

/* lcb_pkg.sv */
// package: register map, field layout and reset values for the counter/boot/diag csrs
`default_nettype none
package lcb_pkg;
  localparam logic [31:0] REVMF_ADDR    = 32'h2000802C;
  localparam logic [31:0] BOOTLO_ADDR   = 32'h20008030;
  localparam logic [31:0] BOOTHI_ADDR   = 32'h20008034;
  localparam logic [31:0] BOOTPR_ADDR   = 32'h20008038;
  localparam logic [31:0] BKPT_ADDR     = 32'h2000803C;
  localparam logic [31:0] MONCMD_ADDR   = 32'h20008040;
  localparam logic [31:0] ZERO_RST      = 32'h00000000;
  localparam logic [31:0] MONCMD_RST    = 32'h00000FFF;
  localparam logic [1:0]  OM_DIAG       = 2'h3;
  localparam int          REV_LSB       = 16;
  localparam int          MON_TRIG_BIT  = 15;
  localparam int          MON_BUS_BIT   = 12;
  localparam int          MON_ADDR_LSB  = 16;
  localparam int          EXAMINE_CYC   = 3;
  localparam logic [1:0]  EXAM_CNT_W1   = 2'h1;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } lcb_bus_req_t;

  typedef struct packed {
    logic        arm;
    logic [14:0] restart;
    logic [15:0] match;
  } lcb_bkpt_t;
endpackage
`default_nettype wire
